// file: src/process_alarm_evaluator.sv
/*
 * Process alarm evaluator: per-channel type compare, standby,
 * on and off delays, AHB-Lite register slave.
 * Assumes value inputs and tick come from logic on i_mclk.
 */
`timescale 1ns/100ps
module process_alarm_evaluator #(
    parameter int TICKS_PER_SEC = alarm_pkg::CYC_PER_SEC, // Cycles a second.
    parameter bit HEATER_FITTED = 1'b0                    // Heater variant.
) (
    input  wire logic                  i_mclk,      // Clock, 200 MHz.
    input  wire logic                  i_reset,     // Async reset, high.
    input  wire logic                  i_hsel,      // AHB select.
    input  wire logic [31:0]           i_haddr,     // AHB address.
    input  wire logic [1:0]            i_htrans,    // AHB transfer type.
    input  wire logic                  i_hwrite,    // AHB write.
    input  wire logic [2:0]            i_hsize,     // AHB size.
    input  wire logic [31:0]           i_hwdata,    // AHB write data.
    input  wire logic                  i_hready,    // AHB bus ready.
    output logic      [31:0]           o_hrdata,    // AHB read data.
    output logic                       o_hreadyout, // AHB slave ready.
    output logic                       o_hresp,     // AHB response.
    input  wire alarm_pkg::values_type i_vals,      // Controller values.
    input  wire logic                  i_tick,      // Sampling tick.
    input  wire logic                  i_loop_break,// Loop break event.
    input  wire logic                  i_rate,      // Rate criterion met.
    input  wire logic                  i_heater,    // heater_alarm level.
    output logic [alarm_pkg::NUM_CH-1:0] o_aux      // Auxiliary outputs.
);
    import alarm_pkg::*;

    // ************************************
    // State
    // ************************************
    typedef struct packed {
        ch_type [NUM_CH-1:0] ch;  // Channels.
        logic                hc;  // Heat and cool control.
        logic [31:0]         sec; // Second prescaler.
        logic                wr;  // Write in data phase.
        logic [7:0]          wa;  // Latched write address.
        logic [31:0]         rd;  // Read data.
    } state_type;

    state_type s_r;   // Registered state.
    state_type s_nxt; // Next state.
    logic      sec_p; // One-second pulse.

    assign sec_p = (s_r.sec == TICKS_PER_SEC - 1);

    // Raw condition of one channel for its type code.
    function automatic logic cond(input ch_type c, input values_type v,
                                  input logic hc, input logic first);
        logic signed [DW+1:0] d;
        logic signed [DW-1:0] mh;
        logic signed [DW-1:0] ml;
        d  = {{2{v.pv[DW-1]}}, v.pv} - {{2{v.sp[DW-1]}}, v.sp};
        mh = v.mv_h;
        ml = hc ? v.mv_c : v.mv_h;
        cond = 1'b0;
        case (c.kind)
            T_BAND_O, T_SB_LO: begin
                cond = d > c.upr || d < -c.lwr;
            end
            T_DEV_HI, 5'h06: begin
                cond = d >= c.val;
            end
            T_DEV_LO, T_SB_HI: begin
                cond = d <= -c.val;
            end
            T_BAND_I: begin
                cond = d <= c.upr && d >= -c.lwr;
            end
            T_ABS_HI, T_SBA_HI: begin
                cond = v.pv > c.val;
            end
            T_ABS_LO, T_SBA_LO: begin
                cond = v.pv < c.val;
            end
            T_LOOP: begin
                cond = first & i_loop_break;
            end
            T_RATE: begin
                cond = i_rate;
            end
            T_SP_HI: begin
                cond = v.sp > c.val;
            end
            T_SP_LO: begin
                cond = v.sp < c.val;
            end
            T_MV_HI: begin
                cond = mh > c.val;
            end
            T_MV_LO: begin
                cond = ml < c.val;
            end
            T_RS_HI: begin
                cond = v.rsp > c.val;
            end
            T_RS_LO: begin
                cond = v.rsp < c.val;
            end
            default: begin
                cond = 1'b0;
            end
        endcase
    endfunction

    // True for the codes that carry a standby sequence.
    function automatic logic stby(input logic [4:0] k);
        stby = (k >= T_SB_LO && k <= T_SB_HI) || k == T_SBA_HI
            || k == T_SBA_LO;
    endfunction

    // Clamp a written delay to the settable range.
    function automatic logic [DLY_W-1:0] clamp(input logic [DLY_W+5:0] x);
        clamp = (x > DLY_MAX) ? DLY_W'(DLY_MAX) : x[DLY_W-1:0];
    endfunction

    // ************************************
    // Next state
    // ************************************
    // Bus decode, channel sampling and delay filters.
    always_comb begin
        logic [7:0] a;
        logic [2:0] ci;
        logic       c;
        logic [DLY_W-1:0] lim;
        a     = 8'h00;
        ci    = 3'h0;
        c     = 1'b0;
        lim   = '0;
        s_nxt = s_r;
        s_nxt.sec = sec_p ? 32'h0 : s_r.sec + 32'h1;
        // Address phase: latch writes, fetch read data.
        s_nxt.wr = i_hsel && i_htrans[1] && i_hready && i_hwrite;
        if (i_hsel && i_htrans[1] && i_hready) begin
            s_nxt.wa = i_haddr[7:0];
            s_nxt.rd = 32'h0;
            a  = i_haddr[7:0];
            ci = a[7:5];
            if (a == OFS_MODE) begin
                s_nxt.rd = {31'h0, s_r.hc};
            end else if (ci < NUM_CH) begin
                case (a[4:0])
                    OFS_CFG[4:0]: begin
                        // Type reads zero while hidden by heater use.
                        s_nxt.rd[4:0] = s_r.ch[ci].heat ? 5'h00
                                      : s_r.ch[ci].kind;
                        s_nxt.rd[CFG_HEAT] = s_r.ch[ci].heat;
                    end
                    OFS_VAL[4:0]: s_nxt.rd = 32'(s_r.ch[ci].val);
                    OFS_UPR[4:0]: s_nxt.rd = 32'(s_r.ch[ci].upr);
                    OFS_LWR[4:0]: s_nxt.rd = 32'(s_r.ch[ci].lwr);
                    OFS_DLY[4:0]: begin
                        s_nxt.rd[DLY_W-1:0] = s_r.ch[ci].don;
                        s_nxt.rd[DLY_OFF+:DLY_W] = s_r.ch[ci].doff;
                    end
                    OFS_STS[4:0]: begin
                        s_nxt.rd[2:0] = {s_r.ch[ci].out, s_r.ch[ci].raw,
                                         s_r.ch[ci].armed};
                    end
                    default: s_nxt.rd = 32'h0;
                endcase
            end
        end
        // Data phase: store the write.
        if (s_r.wr) begin
            a  = s_r.wa;
            ci = a[7:5];
            if (a == OFS_MODE) begin
                s_nxt.hc = i_hwdata[0];
            end else if (ci < NUM_CH) begin
                case (a[4:0])
                    OFS_CFG[4:0]: begin
                        s_nxt.ch[ci].heat = HEATER_FITTED && ci == 3'h0
                                          && i_hwdata[CFG_HEAT];
                        // Loop break is refused away from channel 0.
                        if (i_hwdata[4:0] <= T_RS_LO
                            && (i_hwdata[4:0] != T_LOOP || ci == 3'h0)) begin
                            s_nxt.ch[ci].kind  = i_hwdata[4:0];
                            s_nxt.ch[ci].armed = 1'b1;
                        end
                    end
                    OFS_VAL[4:0]: s_nxt.ch[ci].val = i_hwdata[DW-1:0];
                    OFS_UPR[4:0]: s_nxt.ch[ci].upr = i_hwdata[DW-1:0];
                    OFS_LWR[4:0]: s_nxt.ch[ci].lwr = i_hwdata[DW-1:0];
                    OFS_DLY[4:0]: begin
                        s_nxt.ch[ci].don  = clamp(i_hwdata[DLY_W+5:0]);
                        s_nxt.ch[ci].doff = clamp(i_hwdata[DLY_OFF+:DLY_W+6]);
                    end
                    default: ;
                endcase
            end
        end
        // Channels: sample on the tick, then filter by the delays.
        for (int i = 0; i < NUM_CH; i++) begin
            if (i_tick) begin
                c = s_r.ch[i].heat ? i_heater
                  : cond(s_r.ch[i], i_vals, s_r.hc, i == 0);
                // Standby holds off until the condition first clears; a type
                // write landing in the same cycle re-arms, and the write wins.
                if (!c && !(s_r.wr && s_r.wa == 8'(OFS_CFG + i * CH_STEP))) begin
                    s_nxt.ch[i].armed = 1'b0;
                end
                s_nxt.ch[i].raw = c && !(stby(s_r.ch[i].kind)
                                && s_r.ch[i].armed && !s_r.ch[i].heat);
            end
            lim = s_r.ch[i].raw ? s_r.ch[i].don : s_r.ch[i].doff;
            if (s_r.ch[i].raw == s_r.ch[i].out) begin
                s_nxt.ch[i].cnt = '0;
            end else if (s_r.ch[i].cnt >= lim) begin
                s_nxt.ch[i].out = s_r.ch[i].raw;
                s_nxt.ch[i].cnt = '0;
            end else if (sec_p) begin
                s_nxt.ch[i].cnt = s_r.ch[i].cnt + 1'b1;
            end
        end
    end

    // ************************************
    // Registers
    // ************************************
    // One register for all state.
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                s_r.ch[i].kind  <= RST_TYPE;
                s_r.ch[i].armed <= 1'b1;
            end
            s_r.ch[0].heat <= HEATER_FITTED;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************
    // Outputs
    // ************************************
    // Zero wait states and an OKAY answer always.
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = s_r.rd;
    // Each channel drives the auxiliary output of its own index.
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            o_aux[i] = s_r.ch[i].out;
        end
    end

    // ************************************
    // Assertions
    // ************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    // A write of a type to channel 0.
    sequence wr_cfg0;
        s_r.wr && s_r.wa == OFS_CFG;
    endsequence

    a_aux_follows: assert property (o_aux[0] == s_r.ch[0].out)
        else $error("aux output differs from alarm");
    a_type_off: assert property (i_tick && s_r.ch[0].kind == T_OFF
        && !s_r.ch[0].heat |=> !s_r.ch[0].raw)
        else $error("type off raised alarm");
    a_no_loop: assert property (s_r.ch[NUM_CH-1].kind != T_LOOP)
        else $error("loop break on later channel");
    a_dly_range: assert property (s_r.ch[0].don <= DLY_MAX
        && s_r.ch[0].doff <= DLY_MAX)
        else $error("delay out of range");
    a_on_wait: assert property ($rose(s_r.ch[0].out)
        |-> $past(s_r.ch[0].raw) && $past(s_r.ch[0].cnt)
            >= $past(s_r.ch[0].don))
        else $error("alarm rose early");
    a_off_wait: assert property ($fell(s_r.ch[0].out)
        |-> !$past(s_r.ch[0].raw) && $past(s_r.ch[0].cnt)
            >= $past(s_r.ch[0].doff))
        else $error("alarm fell early");
    a_zero_on: assert property (s_r.ch[0].raw && !s_r.ch[0].out
        && s_r.ch[0].don == 0 ##0 !i_tick |=> s_r.ch[0].out)
        else $error("zero delay not immediate");
    a_dev_hi: assert property (i_tick && !s_r.ch[0].heat
        && s_r.ch[0].kind == T_DEV_HI
        |=> s_r.ch[0].raw == ($past(i_vals.pv) - $past(i_vals.sp)
            >= $past(s_r.ch[0].val)))
        else $error("upper deviation wrong");
    a_stby_hold: assert property (wr_cfg0 ##[1:4] (i_tick
        && stby(s_r.ch[0].kind) && !s_r.ch[0].heat && s_r.ch[0].armed)
        |=> !s_r.ch[0].raw)
        else $error("standby let alarm through");
    a_sp_hi: assert property (i_tick && !s_r.ch[0].heat
        && s_r.ch[0].kind == T_SP_HI
        |=> s_r.ch[0].raw == ($past(i_vals.sp) > $past(s_r.ch[0].val)))
        else $error("set point alarm wrong");
endmodule // process_alarm_evaluator

// file: common/alarm_pkg.sv
/*
 * Shared constants and carriers of the process alarm evaluator.
 * Assumes one 200 MHz clock and a 32-bit AHB-Lite register bus.
 */
package alarm_pkg;
    // ************************************
    // Sizes and timing
    // ************************************
    localparam int NUM_CH     = 2;     // Alarm channels.
    localparam int DW         = 16;    // Signed value width.
    localparam int DLY_W      = 10;    // Delay field width.
    localparam int DLY_MAX    = 999;   // Longest delay in seconds.
    localparam int SECOND_NS  = 1000000000; // One second in ns.
    localparam int CLK_NS     = 5;     // Clock period in ns.
    localparam int CYC_PER_SEC = SECOND_NS / CLK_NS; // Cycles a second.
    // ************************************
    // Alarm type codes
    // ************************************
    localparam logic [4:0] T_OFF    = 5'h00; // No alarm.
    localparam logic [4:0] T_BAND_O = 5'h01; // Outside deviation band.
    localparam logic [4:0] T_DEV_HI = 5'h02; // Upper deviation.
    localparam logic [4:0] T_DEV_LO = 5'h03; // Lower deviation.
    localparam logic [4:0] T_BAND_I = 5'h04; // Inside deviation band.
    localparam logic [4:0] T_SB_LO  = 5'h05; // First standby code.
    localparam logic [4:0] T_SB_HI  = 5'h07; // Last deviation standby.
    localparam logic [4:0] T_ABS_HI = 5'h08; // Value above threshold.
    localparam logic [4:0] T_ABS_LO = 5'h09; // Value below threshold.
    localparam logic [4:0] T_SBA_HI = 5'h0A; // Absolute high, standby.
    localparam logic [4:0] T_SBA_LO = 5'h0B; // Absolute low, standby.
    localparam logic [4:0] T_LOOP   = 5'h0C; // Loop break, channel 0.
    localparam logic [4:0] T_RATE   = 5'h0D; // Rate of change.
    localparam logic [4:0] T_SP_HI  = 5'h0E; // Set point high.
    localparam logic [4:0] T_SP_LO  = 5'h0F; // Set point low.
    localparam logic [4:0] T_MV_HI  = 5'h10; // Output high.
    localparam logic [4:0] T_MV_LO  = 5'h11; // Output low.
    localparam logic [4:0] T_RS_HI  = 5'h12; // Remote set point high.
    localparam logic [4:0] T_RS_LO  = 5'h13; // Remote set point low.
    localparam logic [4:0] RST_TYPE = T_DEV_HI; // Type after reset.
    // ************************************
    // Register map
    // ************************************
    localparam logic [7:0] OFS_CFG  = 8'h00; // Type and heater use.
    localparam logic [7:0] OFS_VAL  = 8'h04; // Alarm value.
    localparam logic [7:0] OFS_UPR  = 8'h08; // Upper deviation.
    localparam logic [7:0] OFS_LWR  = 8'h0C; // Bottom offset.
    localparam logic [7:0] OFS_DLY  = 8'h10; // On and off delays.
    localparam logic [7:0] OFS_STS  = 8'h14; // Channel state.
    localparam logic [7:0] CH_STEP  = 8'h20; // Channel stride.
    localparam logic [7:0] OFS_MODE = 8'h80; // Heat and cool mode.
    localparam int CFG_HEAT = 8;  // Heater use bit in CFG.
    localparam int DLY_OFF  = 16; // Off delay low bit in DLY.
    // Values sampled from the controller.
    typedef struct packed {
        logic signed [DW-1:0] pv;    // process_value.
        logic signed [DW-1:0] sp;    // set_point.
        logic signed [DW-1:0] mv_h;  // manipulated_value, heating.
        logic signed [DW-1:0] mv_c;  // manipulated_value, cooling.
        logic signed [DW-1:0] rsp;   // remote_set_point.
    } values_type;
    // State of one channel.
    typedef struct packed {
        logic [4:0]           kind;  // Type code.
        logic                 heat;  // Channel serves heater_alarm.
        logic signed [DW-1:0] val;   // Alarm value.
        logic signed [DW-1:0] upr;   // Upper deviation.
        logic signed [DW-1:0] lwr;   // Bottom offset.
        logic [DLY_W-1:0]     don;   // On delay in seconds.
        logic [DLY_W-1:0]     doff;  // Off delay in seconds.
        logic [DLY_W-1:0]     cnt;   // Seconds the raw level differs.
        logic                 armed; // Standby still suppressing.
        logic                 raw;   // Sampled condition.
        logic                 out;   // Delayed alarm.
    } ch_type;
endpackage

// file: test/alarm_partner.sv
/*
 * Far-side model: the measurement front end that supplies the sampled values
 * and the sampling tick, and the auxiliary output stage that latches o_aux.
 * Assumes one clock shared with the evaluator and an active-high async reset.
 */
`timescale 1ns/100ps
module alarm_partner
    import alarm_pkg::*;
#(
    parameter int TICK_GAP = 4 // Cycles between sampling ticks.
) (
    input  wire logic              i_mclk,     // Clock.
    input  wire logic              i_reset,    // Async reset, high.
    input  wire values_type        i_set,      // Values the bench wants.
    output values_type             o_vals,     // Values to the evaluator.
    output logic                   o_tick,     // One-cycle sampling tick.
    input  wire logic [NUM_CH-1:0] i_aux,      // Alarm outputs seen.
    output logic [NUM_CH-1:0]      o_aux_seen  // Latched output stage.
);
    int tick_cnt_r; // Counts cycles up to the next tick.
    // ************************************
    // Sampling front end and output stage
    // ************************************
    // Values are registered like a real converter, so they move only on edges.
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            tick_cnt_r <= 0;
            o_tick     <= 1'b0;
            o_vals     <= '0;
            o_aux_seen <= '0;
        end else begin
            tick_cnt_r <= (tick_cnt_r == TICK_GAP - 1) ? 0 : tick_cnt_r + 1;
            o_tick     <= (tick_cnt_r == TICK_GAP - 1);
            o_vals     <= i_set;
            o_aux_seen <= i_aux;
        end
    end
endmodule // alarm_partner

// file: test/process_alarm_evaluator_bench.sv
/*
 * Self-checking bench of the alarm evaluator: AHB-Lite register access,
 * type compares, standby, delays, heater use and random sweeps.
 * Assumes the partner model supplies values and tick; one-second is 10 cycles.
 */
`timescale 1ns/100ps
module process_alarm_evaluator_bench;
    import alarm_pkg::*;
    localparam int TPS   = 10;    // Shortened second for simulation.
    localparam int LIMIT = 30000; // Cycle ceiling of the whole run.
    logic              i_mclk   = 1'b0;
    logic              i_reset  = 1'b1;
    logic              hsel     = 1'b0;
    logic              hwrite   = 1'b0;
    logic [31:0]       haddr    = 32'h0;
    logic [31:0]       hwdata   = 32'h0;
    logic [1:0]        htrans   = 2'h0;
    logic [31:0]       hrdata, dummy;
    logic              hready, hresp, tick;
    logic              loop_brk = 1'b0;
    logic              rate     = 1'b0;
    logic              heater   = 1'b0;
    logic [NUM_CH-1:0] aux, aux_seen;
    values_type        vals;
    values_type        set_vals = '0;
    int                err_count = 0;
    int                num_checks = 0;
    int                cycles = 0;
    int                rnd, mode, c;
    int                tl[15] = '{0, 1, 2, 3, 4, 8, 9, 12, 13, 14, 15, 16, 17, 18, 19};
    int                ty[2], va[2], up[2], lw[2], pv, sp, mh, mc, rs;
    logic [NUM_CH-1:0] ex;
    logic [31:0]       exp_q[$], obs_q[$];
    string             nm_q[$];
    // The clock toggles every 2.5 ns, half of its 5 ns period.
    always #2.5 i_mclk = ~i_mclk;
    process_alarm_evaluator #(.TICKS_PER_SEC(TPS), .HEATER_FITTED(1'b1)) DUT (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_vals(vals), .i_tick(tick), .i_loop_break(loop_brk), .i_rate(rate),
        .i_heater(heater), .o_aux(aux));
    alarm_partner #(.TICK_GAP(4)) far_side (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_set(set_vals), .o_vals(vals),
        .o_tick(tick), .i_aux(aux), .o_aux_seen(aux_seen));
    // ************************************
    // Checking and closing
    // ************************************
    // Compares one result and counts it.
    task automatic check(string nm, logic [31:0] seen, logic [31:0] expv);
        num_checks++;
        if (seen !== expv) begin
            err_count++;
            $display("Error %s expected %08h seen %08h", nm, expv, seen);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // On each rising edge the watcher takes every queued note, oldest first.
    always @(posedge i_mclk) begin
        while (obs_q.size() > 0 && exp_q.size() > 0) begin
            check(nm_q.pop_front(), obs_q.pop_front(), exp_q.pop_front());
        end
    end
    // A hang is cut short here and counted as a mismatch.
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            print_verdict();
        end
    end
    // ************************************
    // Bus and stimulus tasks
    // ************************************
    // One single AHB-Lite word transfer; called right after a rising edge.
    task automatic ahb(logic wr, logic [31:0] a, logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge i_mclk);
        while (hready !== 1'b1) @(posedge i_mclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge i_mclk);
        while (hready !== 1'b1) @(posedge i_mclk);
        rd = hrdata;
    endtask
    // Notes a seen value with its expectation.
    task automatic note(string nm, logic [31:0] seen, logic [31:0] expv);
        nm_q.push_back(nm);
        exp_q.push_back(expv);
        obs_q.push_back(seen);
    endtask
    task automatic wr(logic [31:0] a, logic [31:0] d);
        ahb(1'b1, a, d, dummy);
    endtask
    task automatic rd_chk(string nm, logic [31:0] a, logic [31:0] expv);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        note(nm, r, expv);
    endtask
    task automatic aux_chk(logic [NUM_CH-1:0] expv);
        note("aux", 32'(aux_seen), 32'(expv));
    endtask
    // Hands new controller values to the front end.
    task automatic put(int p, int s, int h, int k, int r);
        set_vals <= {16'(p), 16'(s), 16'(h), 16'(k), 16'(r)};
    endtask
    function automatic logic [31:0] ad(int ch, logic [7:0] ofs);
        return 32'(ofs) + 32'(ch) * 32'(CH_STEP);
    endfunction
    // Expected raw condition of one channel, worked out from the type code.
    function automatic logic cond(int t, int p, int s, int h, int k, int r, int v, int u,
                                  int l, int m, logic lb, logic rt);
        case (t)
            1: return (p - s > u) || (p - s < -l);
            2: return p - s >= v;
            3: return s - p >= v;
            4: return (p - s <= u) && (p - s >= -l);
            8: return p > v;
            9: return p < v;
            12: return lb;
            13: return rt;
            14: return s > v;
            15: return s < v;
            16: return h > v;
            17: return ((m != 0) ? k : h) < v;
            18: return r > v;
            19: return r < v;
            default: return 1'b0;
        endcase
    endfunction
    // ************************************
    // Main sequence
    // ************************************
    initial begin
        rnd = $urandom(51);
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(posedge i_mclk);
        rd_chk("cfg0", ad(0, OFS_CFG), 32'h100);
        rd_chk("cfg1", ad(1, OFS_CFG), 32'(RST_TYPE));
        wr(32'h44, 32'hFFFF_FFFF);
        rd_chk("unmapped", 32'h44, 32'h0);
        wr(ad(1, OFS_CFG), 32'h3);
        wr(ad(1, OFS_CFG), 32'hC);
        rd_chk("cfg1", ad(1, OFS_CFG), 32'h3);
        wr(ad(0, OFS_CFG), 32'h14);
        rd_chk("cfg0", ad(0, OFS_CFG), 32'h2);
        wr(ad(0, OFS_DLY), 32'h03FF_03FF);
        rd_chk("dly", ad(0, OFS_DLY), 32'h03E7_03E7);
        // Two-second delays on an absolute alarm, channel 1 switched off.
        // Both outputs are first let settle low with no delay.
        wr(ad(0, OFS_DLY), 32'h0);
        wr(ad(0, OFS_CFG), 32'h8);
        wr(ad(0, OFS_VAL), 32'h0);
        wr(ad(1, OFS_CFG), 32'h0);
        repeat (10) @(posedge i_mclk);
        aux_chk(2'b00);
        wr(ad(0, OFS_DLY), 32'h0002_0002);
        put(100, 0, 0, 0, 0);
        repeat (12) @(posedge i_mclk);
        aux_chk(2'b00);
        repeat (30) @(posedge i_mclk);
        aux_chk(2'b01);
        put(-100, 0, 0, 0, 0);
        repeat (12) @(posedge i_mclk);
        aux_chk(2'b01);
        repeat (30) @(posedge i_mclk);
        aux_chk(2'b00);
        wr(ad(0, OFS_DLY), 32'h0);
        // Channel 0 serving the heater alarm follows the heater level.
        wr(ad(0, OFS_CFG), 32'h102);
        heater <= 1'b1;
        repeat (10) @(posedge i_mclk);
        aux_chk(2'b01);
        rd_chk("cfg0", ad(0, OFS_CFG), 32'h100);
        heater <= 1'b0;
        repeat (10) @(posedge i_mclk);
        aux_chk(2'b00);
        // Standby types stay quiet until the condition has once been false.
        wr(ad(0, OFS_VAL), 32'd100);
        wr(ad(0, OFS_UPR), 32'd100);
        wr(ad(0, OFS_LWR), 32'd100);
        foreach (tl[i]) begin
            if (i < 5) begin
                c = (i < 3) ? i + 5 : i + 7;
                pv = (c == 7 || c == 11) ? -500 : 500;
                put(pv, 0, 0, 0, 0);
                wr(ad(0, OFS_CFG), 32'(c));
                repeat (10) @(posedge i_mclk);
                aux_chk(2'b00);
                rd_chk("sts", ad(0, OFS_STS), 32'h1);
                put((c == 11) ? 200 : 0, 0, 0, 0, 0);
                repeat (10) @(posedge i_mclk);
                aux_chk(2'b00);
                put(pv, 0, 0, 0, 0);
                repeat (10) @(posedge i_mclk);
                aux_chk(2'b01);
                rd_chk("sts", ad(0, OFS_STS), 32'h6);
            end
        end
        // Random sweep: each channel with its own type and thresholds.
        repeat (60) begin
            mode = $urandom_range(1);
            wr(OFS_MODE, 32'(mode));
            for (int ch = 0; ch < 2; ch++) begin
                ty[ch] = tl[$urandom_range(14)];
                ty[ch] = (ch == 1 && ty[ch] == 12) ? 13 : ty[ch];
                va[ch] = int'($urandom_range(400)) - 200;
                up[ch] = $urandom_range(400);
                lw[ch] = $urandom_range(400);
                wr(ad(ch, OFS_CFG), 32'(ty[ch]));
                wr(ad(ch, OFS_VAL), 32'(va[ch]));
                wr(ad(ch, OFS_UPR), 32'(up[ch]));
                wr(ad(ch, OFS_LWR), 32'(lw[ch]));
            end
            sp = int'($urandom_range(2000)) - 1000;
            pv = int'($urandom_range(2000)) - 1000;
            pv = ($urandom_range(1) == 1) ? sp + va[0] + int'($urandom_range(2)) - 1 : pv;
            mh = int'($urandom_range(400)) - 200;
            mc = int'($urandom_range(400)) - 200;
            rs = int'($urandom_range(400)) - 200;
            put(pv, sp, mh, mc, rs);
            loop_brk <= 1'($urandom_range(1));
            rate <= 1'($urandom_range(1));
            repeat (12) @(posedge i_mclk);
            for (int ch = 0; ch < 2; ch++) begin
                ex[ch] = cond(ty[ch], pv, sp, mh, mc, rs, va[ch], up[ch], lw[ch], mode,
                              loop_brk, rate);
            end
            aux_chk(ex);
        end
        repeat (2) @(posedge i_mclk);
        print_verdict();
    end
endmodule // process_alarm_evaluator_bench
